/* sct_pkg.sv */
// Package for the single channel timer register block: offsets, resets, types.
// Assumes a 32-bit APB master and one system clock.
// What this block does
// (RULE1) The counter advances once per divider input clock count of divider value plus one.
// (RULE2) The counter does not count while the wrap limit is zero.
// (RULE3) In input mode the match register holds the count latched at the last capture, or a later APB match write.
// (RULE4) In output mode the match value is compared to the count to form the channel output.
// (RULE5) With preload off a written match value affects the comparison at once.
// (RULE6) With preload on a written match value takes effect at the next update event.
// (RULE7) Route select 00 pin, 01 calendar clock, 10 crystal clock over 32, 11 main clock out.
// (RULE8) Writing the count register replaces the count and reading returns it.
package sct_pkg;
  localparam logic [7:0]  OFS_COUNT   = 8'h24;
  localparam logic [7:0]  OFS_DIVIDER = 8'h28;
  localparam logic [7:0]  OFS_WRAP    = 8'h2C;
  localparam logic [7:0]  OFS_MATCH   = 8'h34;
  localparam logic [7:0]  OFS_ROUTE   = 8'h50;
  localparam logic [7:0]  OFS_CTRL    = 8'h60;
  localparam logic [15:0] RST_COUNT   = 16'h0000;
  localparam logic [15:0] RST_DIVIDER = 16'h0000;
  localparam logic [15:0] RST_WRAP    = 16'hFFFF;
  localparam logic [15:0] RST_MATCH   = 16'h0000;
  localparam logic [1:0]  RST_ROUTE   = 2'h0;
  // Control register bit positions
  localparam int CTRL_ENABLE  = 0;
  localparam int CTRL_INPUT   = 1;
  localparam int CTRL_PRELOAD = 2;
  localparam logic [4:0] XTAL_DIV_LAST = 5'h1F;
  typedef struct packed {
    logic enable;
    logic inputMode;
    logic preload;
  } sct_ctrl_t;
endpackage

/* sct_timer.sv */
// Single channel 16-bit timer with APB register access.
// Assumes clocks on route inputs are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module sct_timer
  import sct_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        chanPin,
  input  wire logic        calendarClock,
  input  wire logic        externalCrystalClock,
  input  wire logic        mainClockOut,
  output logic             channelOneOutput
);
  logic [15:0] countValue_r, countValue_nxt;
  logic [15:0] divider_r, divider_nxt, divShadow_r, divShadow_nxt;
  logic [15:0] preCnt_r, preCnt_nxt;
  logic [15:0] wrapLimit_r, wrapLimit_nxt;
  logic [15:0] matchValue_r, matchValue_nxt, matchActive_r, matchActive_nxt;
  logic [1:0]  route_r, route_nxt;
  sct_ctrl_t   ctrl_r, ctrl_nxt;
  logic [31:0] prdata_nxt;
  logic        pslverr_nxt, chOut_nxt;
  logic [3:0]  sync1_r, sync2_r;
  logic [4:0]  xtalDiv_r, xtalDiv_nxt;
  logic        xtalPrev_r, xtalOut_r, xtalOut_nxt;
  logic        capPrev_r, capPrev_nxt;
  logic        capIn, capEdge, tick, update, wrEn, hit;

  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] ofs);
    isAddr = (a == ofs);
  endfunction

  // Two-flop synchronisers on the four route inputs
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end
    else if (clkEn)
    begin
      sync1_r <= {mainClockOut, externalCrystalClock, calendarClock, chanPin};
      sync2_r <= sync1_r;
    end
  end

  // Crystal clock divided by 32 (toggle every 16 rising edges)
  always_comb
  begin
    xtalDiv_nxt = xtalDiv_r;
    xtalOut_nxt = xtalOut_r;
    if (sync2_r[2] && !xtalPrev_r)
    begin
      xtalDiv_nxt = xtalDiv_r + 5'h01;
      if (xtalDiv_r[3:0] == XTAL_DIV_LAST[3:0])
        xtalOut_nxt = !xtalOut_r;
    end
  end

  // Input route select
  always_comb
  begin
    unique case (route_r)  // RULE7
      2'h0: capIn = sync2_r[0];
      2'h1: capIn = sync2_r[1];
      2'h2: capIn = xtalOut_r;
      2'h3: capIn = sync2_r[3];
    endcase
  end

  assign capEdge = capIn && !capPrev_r;
  assign capPrev_nxt = capIn;
  assign wrEn = psel && penable && pwrite;
  assign tick = ctrl_r.enable && (wrapLimit_r != 16'h0000) && (preCnt_r == divShadow_r); // RULE2
  assign update = tick && (countValue_r == wrapLimit_r);
  assign hit = (countValue_r < matchActive_r);

  // Timebase, match and register next values
  always_comb
  begin
    countValue_nxt  = countValue_r;
    divider_nxt     = divider_r;
    divShadow_nxt   = divShadow_r;
    preCnt_nxt      = preCnt_r;
    wrapLimit_nxt   = wrapLimit_r;
    matchValue_nxt  = matchValue_r;
    matchActive_nxt = matchActive_r;
    route_nxt       = route_r;
    ctrl_nxt        = ctrl_r;
    // Prescaler divides by divider plus one
    if (ctrl_r.enable && (wrapLimit_r != 16'h0000)) // RULE2
      preCnt_nxt = tick ? 16'h0000 : preCnt_r + 16'h0001; // RULE1
    if (tick)
      countValue_nxt = update ? 16'h0000 : countValue_r + 16'h0001; // RULE1
    if (update)
    begin
      divShadow_nxt = divider_r;
      if (ctrl_r.preload)
        matchActive_nxt = matchValue_r; // RULE6
    end
    if (ctrl_r.inputMode && capEdge)
    begin
      matchValue_nxt  = countValue_r; // RULE3
      matchActive_nxt = countValue_r;
    end
    if (wrEn)
    begin
      if (isAddr(paddr, OFS_COUNT))
        countValue_nxt = pwdata[15:0]; // RULE8
      if (isAddr(paddr, OFS_DIVIDER))
        divider_nxt = pwdata[15:0];
      if (isAddr(paddr, OFS_WRAP))
        wrapLimit_nxt = pwdata[15:0];
      if (isAddr(paddr, OFS_MATCH) && !(ctrl_r.inputMode && capEdge))
      begin
        matchValue_nxt = pwdata[15:0];
        if (!ctrl_r.preload)
          matchActive_nxt = pwdata[15:0]; // RULE5
      end
      if (isAddr(paddr, OFS_ROUTE))
        route_nxt = pwdata[1:0];
      if (isAddr(paddr, OFS_CTRL))
      begin
        ctrl_nxt.enable    = pwdata[CTRL_ENABLE];
        ctrl_nxt.inputMode = pwdata[CTRL_INPUT];
        ctrl_nxt.preload   = pwdata[CTRL_PRELOAD];
      end
    end
    chOut_nxt = !ctrl_r.inputMode && hit; // RULE4
  end

  // Read mux and error answer
  always_comb
  begin
    prdata_nxt  = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    if (psel && !penable)
    begin
      unique case (paddr)
        OFS_COUNT:   prdata_nxt = {16'h0000, countValue_r}; // RULE8
        OFS_DIVIDER: prdata_nxt = {16'h0000, divider_r};
        OFS_WRAP:    prdata_nxt = {16'h0000, wrapLimit_r};
        OFS_MATCH:   prdata_nxt = {16'h0000, matchValue_r};
        OFS_ROUTE:   prdata_nxt = {30'h0000_0000, route_r};
        OFS_CTRL:    prdata_nxt = {29'h0000_0000, ctrl_r.preload, ctrl_r.inputMode,
                                   ctrl_r.enable};
        default:     pslverr_nxt = 1'b1;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      countValue_r     <= RST_COUNT;
      divider_r        <= RST_DIVIDER;
      divShadow_r      <= RST_DIVIDER;
      preCnt_r         <= 16'h0000;
      wrapLimit_r      <= RST_WRAP;
      matchValue_r     <= RST_MATCH;
      matchActive_r    <= RST_MATCH;
      route_r          <= RST_ROUTE;
      ctrl_r           <= '0;
      xtalDiv_r        <= 5'h00;
      xtalPrev_r       <= 1'b0;
      xtalOut_r        <= 1'b0;
      capPrev_r        <= 1'b0;
      prdata           <= 32'h0000_0000;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      channelOneOutput <= 1'b0;
    end
    else if (clkEn)
    begin
      countValue_r     <= countValue_nxt;
      divider_r        <= divider_nxt;
      divShadow_r      <= divShadow_nxt;
      preCnt_r         <= preCnt_nxt;
      wrapLimit_r      <= wrapLimit_nxt;
      matchValue_r     <= matchValue_nxt;
      matchActive_r    <= matchActive_nxt;
      route_r          <= route_nxt;
      ctrl_r           <= ctrl_nxt;
      xtalDiv_r        <= xtalDiv_nxt;
      xtalPrev_r       <= sync2_r[2];
      xtalOut_r        <= xtalOut_nxt;
      capPrev_r        <= capPrev_nxt;
      if (psel && !penable)
      begin
        prdata  <= prdata_nxt;
        pslverr <= pslverr_nxt;
      end
      pready           <= psel && !penable;
      channelOneOutput <= chOut_nxt;
    end
  end

  // Checks
  chk_wrap_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE2
    (clkEn && wrapLimit_r == 16'h0000 && !wrEn) |=> $stable(countValue_r))
    else $error("count moved with zero wrap limit");
  chk_tick_rate: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE1
    (clkEn && tick) |-> (preCnt_r == divShadow_r))
    else $error("tick without full prescale");
  chk_count_step: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE1
    (clkEn && tick && !update && !wrEn) |=> countValue_r == $past(countValue_r) + 16'h0001)
    else $error("count did not step");
  chk_capture_latch: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE3
    (clkEn && ctrl_r.inputMode && capEdge) |=> matchValue_r == $past(countValue_r))
    else $error("capture value wrong");
  chk_output_cmp: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE4
    (clkEn && !ctrl_r.inputMode) |=> channelOneOutput == $past(hit))
    else $error("channel output mismatch");
  chk_direct_match: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE5
    (clkEn && wrEn && paddr == OFS_MATCH && !ctrl_r.preload && !ctrl_r.inputMode)
    |=> matchActive_r == $past(pwdata[15:0]))
    else $error("direct match not applied");
  chk_preload_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE6
    (clkEn && ctrl_r.preload && !update && !(ctrl_r.inputMode && capEdge))
    |=> $stable(matchActive_r))
    else $error("preloaded match changed early");
  chk_count_write: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE8
    (clkEn && wrEn && paddr == OFS_COUNT) |=> countValue_r == $past(pwdata[15:0]))
    else $error("count write lost");
  chk_route_pin: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE7
    (route_r == 2'h0) |-> capIn == sync2_r[0])
    else $error("route select wrong");
endmodule
`default_nettype wire

/* sct_timer_bench.sv */
// Self-checking bench for the single channel timer: APB register access, count rate,
// capture on every input route and compare output with and without preload.
// Assumes the bench is the only APB master and the slave answers on its own pready.
`timescale 1ns/1ps
`default_nettype none
module sct_timer_bench;
  import sct_pkg::*;
  logic        clk_sys;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        chOut;
  logic [3:0]  src;
  logic        xtal;
  logic        xtalRun;
  logic [1:0]  xc;
  logic [31:0] rd;
  logic        slv;
  logic        clkEn;
  logic [31:0] hold0;
  int          err_total;
  int          total_checks;

  sct_timer u_dut (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chanPin(src[0]), .calendarClock(src[1]),
    .externalCrystalClock(xtal), .mainClockOut(src[3]), .channelOneOutput(chOut));

  // System clock, 20 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Crystal clock toggles every third cycle while enabled
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      xc   <= 2'h0;
      xtal <= 1'b0;
    end
    else
    begin
      xc <= (xc == 2'h2) ? 2'h0 : xc + 2'h1;
      if (xtalRun && xc == 2'h2)
        xtal <= ~xtal;
    end
  end

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      err_total++;
      $display("Error pready expected 1 seen 0");
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic cmpVal(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmpBit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    cmpVal(nm, e, rd);
  endtask

  // Counts gained over exactly 40 cycles at a given divider value
  task automatic rate(input logic [31:0] dv, input logic [31:0] e);
    logic [31:0] c0;
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_DIVIDER, dv);
    apb(1'b1, OFS_WRAP, 32'hFFFF);
    apb(1'b1, OFS_COUNT, 32'hFFFE);
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (20) @(posedge clk_sys);
    apb(1'b0, OFS_COUNT, 32'h0);
    c0 = rd;
    repeat (37) @(posedge clk_sys);
    apb(1'b0, OFS_COUNT, 32'h0);
    cmpVal("countRate", e, rd - c0);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    summarize();
  end

  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, src, xtalRun} = '0;
    clkEn = 1'b1;
    err_total = 0;
    total_checks = 0;
    rstn = 1'b0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rdChk(OFS_COUNT, 32'h0, "countRst");
    rdChk(OFS_DIVIDER, 32'h0, "dividerRst");
    rdChk(OFS_WRAP, 32'hFFFF, "wrapRst");
    rdChk(OFS_MATCH, 32'h0, "matchRst");
    rdChk(OFS_ROUTE, 32'h0, "routeRst");
    apb(1'b1, 8'h40, 32'hFFFF);
    cmpBit("slverr", 1'b1, slv);
    apb(1'b1, OFS_COUNT, 32'h1234);
    rdChk(OFS_COUNT, 32'h1234, "countRw");
    cmpBit("slverrOk", 1'b0, slv);
    apb(1'b1, OFS_WRAP, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (20) @(posedge clk_sys);
    rdChk(OFS_COUNT, 32'h1234, "countHeld");
    rate(32'h0, 32'h28);
    // Clock enable low freezes the count: only the three edges before the freeze count
    apb(1'b0, OFS_COUNT, 32'h0);
    hold0 = rd;
    clkEn <= 1'b0;
    repeat (30) @(posedge clk_sys);
    clkEn <= 1'b1;
    apb(1'b0, OFS_COUNT, 32'h0);
    cmpVal("countFrozen", 32'h3, rd - hold0);
    rate(32'h3, 32'hA);
    // Capture through each route; count frozen so the latched value is known
    apb(1'b1, OFS_WRAP, 32'h0);
    for (int r = 0; r < 4; r++)
    begin
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b1, OFS_ROUTE, 32'(r));
      apb(1'b1, OFS_COUNT, 32'h100 + 32'(r));
      apb(1'b1, OFS_CTRL, 32'h3);
      src <= ~(4'h1 << r);
      repeat (10) @(posedge clk_sys);
      rdChk(OFS_MATCH, (r == 0) ? 32'h0 : 32'hFF + 32'(r), "noCapture");
      src[r] <= 1'b1;
      xtalRun <= (r == 2);
      repeat ((r == 2) ? 420 : 10) @(posedge clk_sys);
      xtalRun <= 1'b0;
      rdChk(OFS_MATCH, 32'h100 + 32'(r), "capture");
      src <= 4'h0;
      repeat (5) @(posedge clk_sys);
    end
    // Compare output, preload off then on
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_COUNT, 32'h10);
    apb(1'b1, OFS_MATCH, 32'h20);
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (3) @(posedge clk_sys);
    cmpBit("outHigh", 1'b1, chOut);
    apb(1'b1, OFS_MATCH, 32'h8);
    repeat (2) @(posedge clk_sys);
    cmpBit("outLow", 1'b0, chOut);
    apb(1'b1, OFS_CTRL, 32'h5);
    apb(1'b1, OFS_MATCH, 32'h20);
    repeat (4) @(posedge clk_sys);
    cmpBit("outPreHeld", 1'b0, chOut);
    apb(1'b1, OFS_WRAP, 32'h11);
    repeat (12) @(posedge clk_sys);
    cmpBit("outPreApplied", 1'b1, chOut);
    summarize();
  end
endmodule
`default_nettype wire
